/* File: logic/accessory_pkg.sv */
// Purpose: Shared constants for the accessory controller.
// Assumes: System clock of 40 MHz.
// Notes: Readings are unsigned hundredths of a mag/arcsec^2.
package accessory_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int SECOND_HZ = 1;
    localparam int LED_PULSE_HZ = 60;
    localparam int READING_W = 16;
    localparam int HUM_W = 16;
    localparam int LEVEL_W = 3;
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    // Humidity status codes.
    localparam logic [1:0] HUM_STAT_NONE = 2'h0;
    localparam logic [1:0] HUM_STAT_OK = 2'h1;
    localparam logic [1:0] HUM_STAT_NC = 2'h2;
    // Auto dimming: brighter skies (smaller reading) give a dimmer display.
    localparam logic [15:0] DIM_STEP0 = 16'h03E8;
    localparam logic [15:0] DIM_STEP1 = 16'h05DC;
    localparam logic [15:0] DIM_STEP2 = 16'h07D0;
endpackage

/* File: logic/tick_gen.sv */
// Purpose: Periodic one-cycle tick from a cycle count.
// Assumes: PERIOD of at least one cycle.
// Notes: Counter restarts when run is low.
`timescale 1ns/1ps
module tick_gen #(
    parameter int PERIOD = 40000000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } tick_state_t;
    tick_state_t state;
    tick_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (!run) begin
            next_state.count = 32'h0;
        end else if (state.count == 32'(PERIOD - 1)) begin
            next_state.count = 32'h0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule

/* File: logic/led_pulse.sv */
// Purpose: Stretches a trigger into a fixed-length LED pulse.
// Assumes: LENGTH of at least one cycle.
// Notes: A trigger during a pulse restarts the full length.
`timescale 1ns/1ps
module led_pulse #(
    parameter int LENGTH = 666666
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic trigger,
    output logic led
);
    typedef struct packed {
        logic [31:0] remain;
        logic led;
    } pulse_state_t;
    pulse_state_t state;
    pulse_state_t next_state;

    always_comb begin
        next_state = state;
        if (trigger) begin
            next_state.remain = 32'(LENGTH - 1);
            next_state.led = 1'b1;
        end else if (state.remain != 32'h0) begin
            next_state.remain = state.remain - 32'h1;
        end else begin
            next_state.led = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign led = state.led;
endmodule

/* File: logic/accessory_controller.sv */
// Purpose: Humidity poll, display refresh, LED pulse and relay control.
// Assumes: I2C engine outside; this block issues requests and takes results.
// Notes: One clock, no register bus; settings are plain ports.
// Notes on behaviour
// - While enabled, poll humidity sensor each second and keep latest result.
// - Humidity read command returns stored result, starts no new transaction.
// - No sensor answer sets status to the not-connected code.
// - Send current reading to the four-digit display.
// - Display level fixed 0 to 7, or dimmed automatically in bright skies.
// - Refresh display once per second or on each reading request.
// - Each LED event lights the LED for one sixtieth of a second.
// - LED triggers on new reading or on reading request, by setting.
// - Manual relay mode follows host on/off command.
// - Auto mode: relay on above threshold, off below it.
// - On/off command in auto mode switches to manual and applies it.
`timescale 1ns/1ps
module accessory_controller #(
    parameter int CLK_HZ = accessory_pkg::CLK_HZ
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [accessory_pkg::READING_W-1:0] reading,
    input wire logic reading_new,
    input wire logic reading_req,
    input wire logic hum_enable,
    input wire logic humidity_read_cmd,
    output logic hum_poll_req,
    input wire logic hum_poll_done,
    input wire logic hum_poll_ack,
    input wire logic [accessory_pkg::HUM_W-1:0] hum_poll_data,
    output logic hum_valid,
    output logic [accessory_pkg::HUM_W-1:0] hum_value,
    output logic [1:0] hum_status,
    input wire logic disp_enable,
    input wire logic disp_auto_level,
    input wire logic [accessory_pkg::LEVEL_W-1:0] disp_fixed_level,
    input wire logic disp_on_request,
    output logic disp_req,
    input wire logic disp_done,
    output logic [accessory_pkg::READING_W-1:0] disp_value,
    output logic [accessory_pkg::LEVEL_W-1:0] disp_level,
    input wire logic led_enable,
    input wire logic led_on_request,
    output logic led,
    input wire logic relay_auto_cmd,
    input wire logic relay_on_cmd,
    input wire logic relay_off_cmd,
    input wire logic [accessory_pkg::READING_W-1:0] relay_threshold,
    output logic relay,
    output logic relay_auto
);
    localparam int SECOND_CYCLES = CLK_HZ / accessory_pkg::SECOND_HZ;
    localparam int LED_CYCLES_RAW = CLK_HZ / accessory_pkg::LED_PULSE_HZ;
    localparam int LED_CYCLES = (LED_CYCLES_RAW < 1) ? 1 : LED_CYCLES_RAW;

    typedef enum logic [1:0] {
        HUM_IDLE,
        HUM_WAIT
    } hum_phase_t;

    typedef struct packed {
        hum_phase_t hum_phase;
        logic hum_valid;
        logic [accessory_pkg::HUM_W-1:0] hum_value;
        logic [1:0] hum_status;
        logic [accessory_pkg::HUM_W-1:0] hum_latest;
        logic [1:0] hum_latest_status;
        logic disp_busy;
        logic disp_pending;
        logic [accessory_pkg::READING_W-1:0] disp_value;
        logic [accessory_pkg::LEVEL_W-1:0] disp_level;
        logic relay;
        logic relay_auto;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic sec_tick;
    logic led_trigger;
    logic disp_event;
    logic [accessory_pkg::LEVEL_W-1:0] auto_level;

    tick_gen #(
        .PERIOD(SECOND_CYCLES)
    ) second_timer (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(1'b1),
        .tick(sec_tick)
    );

    assign led_trigger = led_enable && (led_on_request ? reading_req : reading_new);

    led_pulse #(
        .LENGTH(LED_CYCLES)
    ) indicator (
        .mclk(mclk),
        .rst_b(rst_b),
        .trigger(led_trigger),
        .led(led)
    );

    // Bright skies give small readings, so the level drops as the reading falls.
    always_comb begin
        if (reading < accessory_pkg::DIM_STEP0) begin
            auto_level = 3'h0;
        end else if (reading < accessory_pkg::DIM_STEP1) begin
            auto_level = 3'h2;
        end else if (reading < accessory_pkg::DIM_STEP2) begin
            auto_level = 3'h4;
        end else begin
            auto_level = accessory_pkg::LEVEL_MAX;
        end
    end

    assign disp_event = disp_on_request ? reading_req : sec_tick;

    always_comb begin
        next_state = state;
        next_state.hum_valid = 1'b0;

        // Humidity polling runs in the background of the command path.
        unique case (state.hum_phase)
            HUM_IDLE: begin
                if (hum_enable && sec_tick) begin
                    next_state.hum_phase = HUM_WAIT;
                end
            end
            HUM_WAIT: begin
                if (hum_poll_done) begin
                    next_state.hum_phase = HUM_IDLE;
                    if (hum_poll_ack) begin
                        next_state.hum_latest = hum_poll_data;
                        next_state.hum_latest_status = accessory_pkg::HUM_STAT_OK;
                    end else begin
                        next_state.hum_latest_status = accessory_pkg::HUM_STAT_NC;
                    end
                end
            end
            default: begin
                next_state.hum_phase = HUM_IDLE;
            end
        endcase

        if (humidity_read_cmd) begin
            next_state.hum_value = state.hum_latest;
            next_state.hum_status = state.hum_latest_status;
            next_state.hum_valid = 1'b1;
        end

        // A refresh that lands while the display is busy is held, not dropped.
        if (disp_enable && disp_event) begin
            next_state.disp_pending = 1'b1;
        end
        if (state.disp_busy) begin
            if (disp_done) begin
                next_state.disp_busy = 1'b0;
            end
        end else if (state.disp_pending) begin
            next_state.disp_pending = disp_enable && disp_event;
            next_state.disp_busy = 1'b1;
            next_state.disp_value = reading;
            next_state.disp_level = disp_auto_level ? auto_level : disp_fixed_level;
        end

        if (relay_on_cmd || relay_off_cmd) begin
            next_state.relay_auto = 1'b0;
            next_state.relay = relay_on_cmd;
        end else begin
            if (relay_auto_cmd) begin
                next_state.relay_auto = 1'b1;
            end
            // The first auto command must not skip a threshold decision.
            if (state.relay_auto || relay_auto_cmd) begin
                if (reading > relay_threshold) begin
                    next_state.relay = 1'b1;
                end else if (reading < relay_threshold) begin
                    next_state.relay = 1'b0;
                end
                // Equal reading keeps the relay as it is.
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign hum_poll_req = (state.hum_phase == HUM_WAIT);
    assign hum_valid = state.hum_valid;
    assign hum_value = state.hum_value;
    assign hum_status = state.hum_status;
    assign disp_req = state.disp_busy;
    assign disp_value = state.disp_value;
    assign disp_level = state.disp_level;
    assign relay = state.relay;
    assign relay_auto = state.relay_auto;
endmodule

/* File: test/accessory_controller_properties.sv */
// Purpose: Port timing checks for the accessory controller.
// Assumes: One clock, reset low, CLK_HZ as set on the design.
// Notes: The LED bound assumes no retrigger while the pulse runs.
`timescale 1ns/1ps
module accessory_controller_properties #(parameter int CLK_HZ = 600) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reading,
    input wire logic [15:0] relay_threshold,
    input wire logic humidity_read_cmd,
    input wire logic hum_valid,
    input wire logic hum_poll_req,
    input wire logic hum_poll_done,
    input wire logic disp_req,
    input wire logic disp_done,
    input wire logic led,
    input wire logic relay_on_cmd,
    input wire logic relay_off_cmd,
    input wire logic relay,
    input wire logic relay_auto
);
    localparam int LED_N = CLK_HZ / 60;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic auto_idle;
    assign auto_idle = relay_auto && !relay_on_cmd && !relay_off_cmd;
    property p_read; humidity_read_cmd |=> hum_valid; endproperty
    a_read: assert property (p_read) else $error("no humidity answer");
    property p_poll; hum_poll_req && !hum_poll_done |=> hum_poll_req; endproperty
    a_poll: assert property (p_poll) else $error("poll dropped early");
    property p_disp; disp_req && !disp_done |=> disp_req; endproperty
    a_disp: assert property (p_disp) else $error("display write dropped");
    property p_led; $rose(led) |-> led[*8] ##[1:LED_N] !led; endproperty
    a_led: assert property (p_led) else $error("led pulse length");
    property p_on; relay_on_cmd |=> relay && !relay_auto; endproperty
    a_on: assert property (p_on) else $error("relay on");
    property p_off; relay_off_cmd && !relay_on_cmd |=> !relay && !relay_auto; endproperty
    a_off: assert property (p_off) else $error("relay off");
    property p_hi; auto_idle && reading > relay_threshold |=> relay; endproperty
    a_hi: assert property (p_hi) else $error("auto relay high");
    property p_eq; auto_idle && reading == relay_threshold |=> $stable(relay); endproperty
    a_eq: assert property (p_eq) else $error("auto relay equal");
endmodule
bind accessory_controller accessory_controller_properties #(.CLK_HZ(CLK_HZ)) chk (
    .mclk(mclk), .rst_b(rst_b), .reading(reading), .relay_threshold(relay_threshold),
    .humidity_read_cmd(humidity_read_cmd), .hum_valid(hum_valid), .led(led),
    .hum_poll_req(hum_poll_req), .hum_poll_done(hum_poll_done), .disp_req(disp_req),
    .disp_done(disp_done), .relay_on_cmd(relay_on_cmd), .relay_off_cmd(relay_off_cmd),
    .relay(relay), .relay_auto(relay_auto));

/* File: test/accessory_partner.sv */
// Purpose: Far-side model of the humidity sensor and the display.
// Assumes: Requests are levels held until the done pulse.
// Notes: Sensor answers slowly, display promptly; data idles high like a pulled-up line.
`timescale 1ns/1ps
module accessory_partner (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic present,
    input wire logic hum_poll_req,
    output logic hum_poll_done,
    output logic hum_poll_ack,
    output logic [15:0] hum_poll_data,
    input wire logic disp_req,
    output logic disp_done
);
    logic [3:0] wait_cnt;
    assign hum_poll_ack = hum_poll_done && present;
    assign hum_poll_data = hum_poll_ack ? 16'h1234 : 16'hFFFF;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            hum_poll_done <= 1'h0;
            disp_done <= 1'h0;
        end else begin
            disp_done <= disp_req && !disp_done;
            hum_poll_done <= hum_poll_req && !hum_poll_done && wait_cnt == 4'h5;
            wait_cnt <= (hum_poll_req && !hum_poll_done) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: test/accessory_controller_tb.sv */
// Purpose: Self-checking bench for the accessory controller.
// Assumes: CLK_HZ shortened to 600, so a second is 600 cycles and the LED 10.
// Notes: Inputs move 2 ns after the rising edge.
`timescale 1ns/1ps
module accessory_controller_tb;
    localparam int HZ = 600;
    logic mclk = '0, rst_b = '0, present = '0, hum_enable = '0, disp_enable = '0;
    logic disp_auto_level = '0, disp_on_request = '1, led_enable = '0, led_on_request = '0;
    logic [5:0] cmd = 6'h00;
    logic [15:0] reading = 16'h0000, relay_threshold = 16'h0800;
    logic [2:0] disp_fixed_level = 3'h5;
    wire reading_new, reading_req, humidity_read_cmd, relay_auto_cmd, relay_on_cmd, relay_off_cmd;
    logic hum_poll_req, hum_poll_done, hum_poll_ack, hum_valid, disp_req, disp_done;
    logic led, relay, relay_auto;
    logic [15:0] hum_poll_data, hum_value, disp_value;
    logic [2:0] disp_level;
    logic [1:0] hum_status;
    logic [15:0] rd [6] = '{16'h0700, 16'h03E7, 16'h03E8, 16'h05DB, 16'h05DC, 16'h07D0};
    logic [2:0] lv [6] = '{3'h5, 3'h0, 3'h2, 3'h2, 3'h4, 3'h7};
    int err_count = 0, tests_run = 0, n;
    time t0;
    assign {reading_new, reading_req, humidity_read_cmd, relay_auto_cmd, relay_on_cmd,
        relay_off_cmd} = cmd;
    accessory_controller #(.CLK_HZ(HZ)) dut (.*);
    accessory_partner far (.*);
    initial forever #12.5 mclk = ~mclk;
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    // A spare cycle before each command keeps pulses apart.
    task automatic pulse(input logic [5:0] m);
        step(1);
        cmd = m;
        step(1);
        cmd = 6'h00;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        err_count++;
        summarize;
    end
    initial begin
        step(12);
        rst_b = '1;
        check({relay, relay_auto, led, hum_valid, disp_req}, 5'h00);
        pulse(6'h02);
        check({relay, relay_auto}, 2'h2);
        pulse(6'h01);
        check({relay, relay_auto}, 2'h0);
        reading = 16'h0900;
        pulse(6'h04);
        step(1);
        check({relay, relay_auto}, 2'h3);
        reading = 16'h0800;
        step(2);
        check({relay, relay_auto}, 2'h3);
        reading = 16'h0700;
        step(2);
        check({relay, relay_auto}, 2'h1);
        pulse(6'h02);
        check({relay, relay_auto}, 2'h2);
        hum_enable = '1;
        for (n = 0; !hum_poll_req && n < 700; n++) step(1);
        t0 = $time;
        for (n = 0; hum_poll_req && n < 50; n++) step(1);
        pulse(6'h08);
        check({hum_valid, hum_poll_req}, 2'h2);
        check(hum_status, accessory_pkg::HUM_STAT_NC);
        present = '1;
        for (n = 0; !hum_poll_req && n < 700; n++) step(1);
        check(16'($time - t0), 16'(HZ * 25));
        for (n = 0; hum_poll_req && n < 50; n++) step(1);
        pulse(6'h08);
        check(hum_value, 16'h1234);
        check(hum_status, accessory_pkg::HUM_STAT_OK);
        led_enable = '1;
        pulse(6'h20);
        for (n = 0; led && n < 50; n++) step(1);
        check(16'(n >= HZ / 60 && n <= HZ / 60 + 1), 16'h0001);
        led_on_request = '1;
        pulse(6'h20);
        check(led, 1'h0);
        pulse(6'h10);
        check(led, 1'h1);
        led_on_request = '0;
        disp_enable = '1;
        for (int i = 0; i < 6; i++) begin
            disp_auto_level = (i > 0);
            reading = rd[i];
            pulse(6'h10);
            for (n = 0; !disp_req && n < 20; n++) step(1);
            check(disp_value, rd[i]);
            check(disp_level, lv[i]);
            for (n = 0; disp_req && n < 20; n++) step(1);
        end
        disp_on_request = '0;
        for (n = 0; !disp_req && n < 700; n++) step(1);
        check(disp_req, 1'h1);
        summarize;
    end
endmodule
